// ==== hw/ssc_pkg.sv ====
// Constants, record layout and state type of the step sequence controller.
// Assumes a single 40 MHz clock shared by every design file.
package ssc_pkg;

   // =========================================================================
   // Widths
   localparam int STEP_W = 8;
   localparam int BANK_W = 2;
   localparam int CNT_W = 10;
   localparam int VAL_W = 16;
   localparam int TIME_W = 16;
   localparam int NQ = 2;

   // =========================================================================
   // Step record field positions
   localparam int F_TIME = 0;
   localparam int F_END = 16;
   localparam int F_JT = 18;
   localparam int F_JR = 26;
   localparam int F_BA = 36;
   localparam int F_BB = 44;
   localparam int F_MK = 52;
   localparam int F_MKOP = 54;
   localparam int F_DC = 55;
   localparam int F_DCOP = 71;
   localparam int F_AC = 73;
   localparam int F_ACOP = 89;
   localparam int REC_W = 91;
   localparam int Q_VAL[NQ] = '{F_DC, F_AC};
   localparam int Q_OP[NQ] = '{F_DCOP, F_ACOP};

   // =========================================================================
   // Encodings
   localparam logic [1:0] END_CONTINUE_SEQUENCE = 2'h0;
   localparam logic [1:0] END_STOP = 2'h1;
   localparam logic [1:0] END_HOLD = 2'h2;
   localparam logic [1:0] OP_FIXED = 2'h0;
   localparam logic [1:0] OP_RETAIN = 2'h1;
   localparam logic [1:0] OP_RAMP = 2'h2;
   localparam logic MK_RETAIN = 1'b1;
   localparam logic [STEP_W-1:0] STEP_NONE = 8'h00;
   localparam logic [STEP_W-1:0] STEP_FIRST = 8'h01;
   localparam logic [STEP_W-1:0] STEP_LAST = 8'hFF;
   localparam logic [CNT_W-1:0] REP_INF = 10'h000;
   localparam logic [TIME_W-1:0] TIME_MIN = 16'h0001;
   localparam logic [1:0] MARK_IDLE = 2'h0;
   localparam logic [REC_W-1:0] INIT_REC = {75'h0, TIME_MIN};

   // =========================================================================
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int CLEAR_S = 6;
   localparam int CLEAR_CYC = CLEAR_S * CLK_HZ;

   typedef enum {S_IDLE, S_LOAD, S_RUN, S_HOLD, S_CLEAR} ssc_state_e;

endpackage

// ==== hw/ssc_mem.sv ====
// Simple dual-port memory with registered read data.
// Assumes write and read on the same clock; read returns old data on a clash.
module ssc_mem #(
   parameter int W = 8,
   parameter int D = 256
) (
   // Clock
   input wire logic clock_i,
   // Write port
   input wire logic we_i,
   input wire logic [$clog2(D)-1:0] waddr_i,
   input wire logic [W-1:0] wdata_i,
   // Read port
   input wire logic [$clog2(D)-1:0] raddr_i,
   output logic [W-1:0] rdata_o
);
   logic [W-1:0] mem [D];

   always_ff @(posedge clock_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule // ssc_mem

// ==== hw/ssc_top.sv ====
// Step sequence controller: walks stored program steps and drives levels.
// Assumes commands are one-cycle pulses from logic on clock_i.
//
// Contract
// - At step end apply end action: continue, stop to Idle, hold to Hold.
// - After a step, jump target zero advances; 1..255 goes to that step.
// - Jump repeats as many times as the repeat count; zero means forever.
// - Each step holds two branch targets; zero disables that branch.
// - Branch command enters matching target step; disabled target ignored.
// - Start begins execution and enters Run mode.
// - Stop ends execution and returns to Idle mode.
// - Hold pauses execution in place and enters Hold mode.
// - Start and every control command except clear accepted only while output enabled.
// - Edited fixed values of the current step reach the outputs while in Run, but not in Hold or Idle.
// - Four program stores: two ranges times two internal modes.
// - Edits go straight into sequence memory; edits made while clear writes memory are lost.
// - Clear erases memory, loads initial values; commands wait until done.
// - DC level used only in AC plus DC mode, zero in AC only.
// - Marker output carries step code, forced low in Idle.
// - Per quantity: fixed value, retain previous, or linear ramp.
module ssc_top #(
   parameter int TICK_CYC = ssc_pkg::TICK_CYC,
   parameter int CLEAR_CYC = ssc_pkg::CLEAR_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   // Commands
   input wire logic output_on_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic hold_i,
   input wire logic branch_command_a_i,
   input wire logic branch_command_b_i,
   input wire logic clear_i,
   // Store select
   input wire logic range_200v_i,
   input wire logic ac_dc_internal_mode_i,
   // Program edit port
   input wire logic edit_we_i,
   input wire logic [ssc_pkg::BANK_W-1:0] edit_bank_i,
   input wire logic [ssc_pkg::STEP_W-1:0] edit_step_i,
   input wire logic [ssc_pkg::REC_W-1:0] edit_data_i,
   // Levels and status
   output logic [ssc_pkg::VAL_W-1:0] dc_level_o,
   output logic [ssc_pkg::VAL_W-1:0] ac_level_o,
   output logic [1:0] step_marker_code_o,
   output logic [ssc_pkg::STEP_W-1:0] step_number_o,
   output logic idle_o,
   output logic run_o,
   output logic hold_o,
   output logic clearing_o
);
   localparam int TK_W = $clog2(TICK_CYC);
   localparam int CL_W = $clog2(CLEAR_CYC);
   localparam int AD_W = ssc_pkg::BANK_W + ssc_pkg::STEP_W;
   localparam int NREC = 1 << AD_W;

   ssc_pkg::ssc_state_e state;
   logic [ssc_pkg::STEP_W-1:0] cur;
   logic lcnt;
   logic [TK_W-1:0] tick_cnt;
   logic [ssc_pkg::TIME_W-1:0] elapsed;
   logic [CL_W-1:0] clr_cnt;
   logic p_start, p_stop, p_hold, p_bra, p_brb;
   logic [1:0] marker;
   logic [ssc_pkg::VAL_W-1:0] lvl [ssc_pkg::NQ];

   // =========================================================================
   // Memories
   logic [ssc_pkg::REC_W-1:0] rec;
   logic [ssc_pkg::CNT_W-1:0] jc_rd;
   logic clr_wr;
   logic [AD_W-1:0] clr_addr;
   logic prog_we;
   logic [AD_W-1:0] prog_waddr;
   logic [ssc_pkg::REC_W-1:0] prog_wdata;
   logic jc_we;
   logic [ssc_pkg::STEP_W-1:0] jc_waddr;
   logic [ssc_pkg::CNT_W-1:0] jc_wdata;
   logic [ssc_pkg::CNT_W-1:0] jc_next;

   assign clr_wr = (state == ssc_pkg::S_CLEAR) && (clr_cnt < CL_W'(NREC));
   assign clr_addr = clr_cnt[AD_W-1:0];
   assign prog_we = clr_wr | edit_we_i;
   assign prog_waddr = clr_wr ? clr_addr : {edit_bank_i, edit_step_i};
   assign prog_wdata = clr_wr ? ssc_pkg::INIT_REC : edit_data_i;

   ssc_mem #(.W(ssc_pkg::REC_W), .D(NREC)) u_prog (
      .clock_i(clock_i),
      .we_i(prog_we),
      .waddr_i(prog_waddr),
      .wdata_i(prog_wdata),
      .raddr_i({ac_dc_internal_mode_i, range_200v_i, cur}),
      .rdata_o(rec)
   );

   // =========================================================================
   // Step fields
   logic [ssc_pkg::TIME_W-1:0] s_time;
   logic [1:0] s_end;
   logic [ssc_pkg::STEP_W-1:0] s_jt, s_ba, s_bb;
   logic [ssc_pkg::CNT_W-1:0] s_jr;
   logic [1:0] s_mk;
   logic s_mkop;

   assign s_time = (rec[ssc_pkg::F_TIME +: ssc_pkg::TIME_W] == '0) ?
                   ssc_pkg::TIME_MIN : rec[ssc_pkg::F_TIME +: ssc_pkg::TIME_W];
   assign s_end = rec[ssc_pkg::F_END +: 2];
   assign s_jt = rec[ssc_pkg::F_JT +: ssc_pkg::STEP_W];
   assign s_jr = rec[ssc_pkg::F_JR +: ssc_pkg::CNT_W];
   assign s_ba = rec[ssc_pkg::F_BA +: ssc_pkg::STEP_W];
   assign s_bb = rec[ssc_pkg::F_BB +: ssc_pkg::STEP_W];
   assign s_mk = rec[ssc_pkg::F_MK +: 2];
   assign s_mkop = rec[ssc_pkg::F_MKOP];

   // =========================================================================
   // Jump decision
   logic in_run, tick, step_end, apply, jump_ok, wrap;
   logic [ssc_pkg::STEP_W-1:0] nxt;

   assign in_run = (state == ssc_pkg::S_RUN);
   assign tick = in_run && (tick_cnt == TK_W'(TICK_CYC - 1));
   assign step_end = in_run && (elapsed >= s_time);
   assign apply = (state == ssc_pkg::S_LOAD) && lcnt;
   assign jump_ok = (s_jt != ssc_pkg::STEP_NONE) &&
                    ((s_jr == ssc_pkg::REP_INF) || (jc_rd < s_jr));
   assign nxt = jump_ok ? s_jt : cur + ssc_pkg::STEP_FIRST;
   assign wrap = !jump_ok && (cur == ssc_pkg::STEP_LAST);
   assign jc_next = !jump_ok ? '0 :
                    (s_jr == ssc_pkg::REP_INF) ? jc_rd :
                    jc_rd + CNT_W_ONE();
   assign jc_we = clr_wr | (step_end && (s_jt != ssc_pkg::STEP_NONE));
   assign jc_waddr = clr_wr ? clr_addr[ssc_pkg::STEP_W-1:0] : cur;
   assign jc_wdata = clr_wr ? '0 : jc_next;

   function automatic logic [ssc_pkg::CNT_W-1:0] CNT_W_ONE();
      CNT_W_ONE = {{(ssc_pkg::CNT_W-1){1'b0}}, 1'b1};
   endfunction

   ssc_mem #(.W(ssc_pkg::CNT_W), .D(1 << ssc_pkg::STEP_W)) u_jcnt (
      .clock_i(clock_i),
      .we_i(jc_we),
      .waddr_i(jc_waddr),
      .wdata_i(jc_wdata),
      .raddr_i(cur),
      .rdata_o(jc_rd)
   );

   // =========================================================================
   // Commands, queued while clearing
   logic busy, c_start, c_stop, c_hold, c_bra, c_brb;

   assign busy = (state == ssc_pkg::S_CLEAR);
   assign c_start = !busy && output_on_i && (start_i | p_start);
   assign c_stop = !busy && output_on_i && (stop_i | p_stop);
   assign c_hold = !busy && output_on_i && (hold_i | p_hold);
   assign c_bra = !busy && output_on_i && (branch_command_a_i | p_bra) &&
                  (s_ba != ssc_pkg::STEP_NONE);
   assign c_brb = !busy && output_on_i && (branch_command_b_i | p_brb) &&
                  (s_bb != ssc_pkg::STEP_NONE);

   always_ff @(posedge clock_i) begin
      if (!nrst_i || !busy) begin
         p_start <= 1'b0;
         p_stop <= 1'b0;
         p_hold <= 1'b0;
         p_bra <= 1'b0;
         p_brb <= 1'b0;
      end else begin
         p_start <= p_start | start_i;
         p_stop <= p_stop | stop_i;
         p_hold <= p_hold | hold_i;
         p_bra <= p_bra | branch_command_a_i;
         p_brb <= p_brb | branch_command_b_i;
      end
   end

   // =========================================================================
   // Sequencer
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         state <= ssc_pkg::S_IDLE;
         cur <= ssc_pkg::STEP_FIRST;
         lcnt <= 1'b0;
         clr_cnt <= '0;
      end else if (clear_i && !busy) begin
         state <= ssc_pkg::S_CLEAR;
         clr_cnt <= '0;
      end else begin
         lcnt <= 1'b0;
         case (state)
            ssc_pkg::S_CLEAR: begin
               clr_cnt <= clr_cnt + CL_W'(1);
               if (clr_cnt == CL_W'(CLEAR_CYC - 1)) begin
                  state <= ssc_pkg::S_IDLE;
                  cur <= ssc_pkg::STEP_FIRST;
               end
            end
            ssc_pkg::S_IDLE: begin
               if (c_start) begin
                  cur <= ssc_pkg::STEP_FIRST;
                  state <= ssc_pkg::S_LOAD;
               end
            end
            ssc_pkg::S_LOAD: begin
               lcnt <= 1'b1;
               if (c_stop) begin
                  state <= ssc_pkg::S_IDLE;
               end else if (c_hold) begin
                  lcnt <= 1'b0;
                  state <= ssc_pkg::S_HOLD;
               end else if (lcnt) begin
                  lcnt <= 1'b0;
                  state <= ssc_pkg::S_RUN;
               end
            end
            ssc_pkg::S_RUN, ssc_pkg::S_HOLD: begin
               if (c_stop) begin
                  state <= ssc_pkg::S_IDLE;
               end else if (c_hold) begin
                  state <= ssc_pkg::S_HOLD;
               end else if (c_bra) begin
                  cur <= s_ba;
                  state <= ssc_pkg::S_LOAD;
               end else if (c_brb) begin
                  cur <= s_bb;
                  state <= ssc_pkg::S_LOAD;
               end else if (c_start && state == ssc_pkg::S_HOLD) begin
                  state <= ssc_pkg::S_RUN;
               end else if (step_end) begin
                  cur <= nxt;
                  if (s_end == ssc_pkg::END_STOP || wrap) begin
                     state <= ssc_pkg::S_IDLE;
                  end else if (s_end == ssc_pkg::END_HOLD) begin
                     state <= ssc_pkg::S_HOLD;
                  end else begin
                     state <= ssc_pkg::S_LOAD;
                  end
               end
            end
            default: state <= ssc_pkg::S_IDLE;
         endcase
      end
   end

   // Step timer, restarted in every Load and frozen in Hold
   always_ff @(posedge clock_i) begin
      if (!nrst_i || state == ssc_pkg::S_LOAD) begin
         tick_cnt <= '0;
         elapsed <= '0;
      end else if (in_run) begin
         tick_cnt <= tick ? '0 : tick_cnt + TK_W'(1);
         if (tick && elapsed != '1) begin
            elapsed <= elapsed + ssc_pkg::TIME_MIN;
         end
      end
   end

   // =========================================================================
   // Output quantities
   for (genvar q = 0; q < ssc_pkg::NQ; q++) begin : g_q
      logic [ssc_pkg::VAL_W-1:0] tgt;
      logic [1:0] op;
      logic [31:0] rem;
      logic [31:0] mag;
      logic [31:0] t32;
      logic up;

      assign tgt = rec[ssc_pkg::Q_VAL[q] +: ssc_pkg::VAL_W];
      assign op = rec[ssc_pkg::Q_OP[q] +: 2];
      assign t32 = {16'h0000, s_time};
      assign up = tgt > lvl[q];

      always_ff @(posedge clock_i) begin
         if (!nrst_i) begin
            lvl[q] <= '0;
            rem <= '0;
            mag <= '0;
         end else if (apply) begin
            rem <= '0;
            mag <= {16'h0000, up ? tgt - lvl[q] : lvl[q] - tgt};
            if (op == ssc_pkg::OP_FIXED) begin
               lvl[q] <= tgt;
            end
         end else if (in_run) begin
            if (op == ssc_pkg::OP_FIXED) begin
               lvl[q] <= tgt;
            end else if (op == ssc_pkg::OP_RAMP) begin
               if (step_end) begin
                  lvl[q] <= tgt;
               end else if (rem >= t32 && lvl[q] != tgt) begin
                  lvl[q] <= up ? lvl[q] + 16'h0001 : lvl[q] - 16'h0001;
                  rem <= rem - t32 + (tick ? mag : 32'h0000_0000);
               end else if (tick) begin
                  rem <= rem + mag;
               end
            end
         end
      end
   end

   // Marker code keeps the last code when its step asks to retain
   always_ff @(posedge clock_i) begin
      if (!nrst_i || state == ssc_pkg::S_IDLE || busy) begin
         marker <= ssc_pkg::MARK_IDLE;
      end else if ((apply || in_run) && s_mkop != ssc_pkg::MK_RETAIN) begin
         marker <= s_mk;
      end
   end

   // =========================================================================
   // Outputs
   assign dc_level_o = ac_dc_internal_mode_i ? lvl[0] : '0;
   assign ac_level_o = lvl[1];
   // Idle forces the code low in the same cycle the mode is entered
   assign step_marker_code_o = (state == ssc_pkg::S_IDLE) ?
                               ssc_pkg::MARK_IDLE : marker;
   assign step_number_o = cur;
   assign idle_o = (state == ssc_pkg::S_IDLE);
   assign run_o = in_run || (state == ssc_pkg::S_LOAD);
   assign hold_o = (state == ssc_pkg::S_HOLD);
   assign clearing_o = busy;
endmodule // ssc_top

// ==== bench/ssc_top_monitor.sv ====
// Checker module for ssc_top, bound to its ports.
// Assumes one clock and the synchronous active-low reset.
module ssc_top_monitor #(
   parameter int CLEAR_CYC = 2048
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   // Commands
   input wire logic output_on_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic hold_i,
   input wire logic branch_command_a_i,
   input wire logic branch_command_b_i,
   input wire logic ac_dc_internal_mode_i,
   // Status
   input wire logic [ssc_pkg::VAL_W-1:0] dc_level_o,
   input wire logic [1:0] step_marker_code_o,
   input wire logic [ssc_pkg::STEP_W-1:0] step_number_o,
   input wire logic idle_o,
   input wire logic run_o,
   input wire logic hold_o,
   input wire logic clearing_o
);
   // ==========================================================
   // Helpers
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   int clr_cnt;
   logic any_br;
   assign any_br = branch_command_a_i || branch_command_b_i;
   always_ff @(posedge clock_i) begin
      if (!nrst_i || !clearing_o) begin
         clr_cnt <= 0;
      end else begin
         clr_cnt <= clr_cnt + 1;
      end
   end
   sequence s_start_req;
      idle_o && !clearing_o && output_on_i && start_i && !any_br
         && !stop_i && !hold_i;
   endsequence
   sequence s_held;
      hold_o ##1 hold_o;
   endsequence
   // ==========================================================
   // Assertions
   AST_START: assert property (s_start_req |=> run_o)
      else $error("start did not enter run");
   AST_STOP: assert property (output_on_i && stop_i && !clearing_o
      |=> idle_o)
      else $error("stop did not enter idle");
   AST_HOLD: assert property (output_on_i && hold_i && !stop_i && run_o
      && !clearing_o |=> hold_o)
      else $error("hold did not enter hold");
   AST_GATE: assert property (!output_on_i && idle_o && !clearing_o
      |=> idle_o)
      else $error("command taken with output off");
   AST_MARK: assert property (idle_o
      |-> step_marker_code_o == ssc_pkg::MARK_IDLE)
      else $error("marker not low in idle");
   AST_DC_OFF: assert property (!ac_dc_internal_mode_i
      |-> dc_level_o == '0)
      else $error("dc level used in ac only mode");
   AST_HOLD_STEP: assert property (s_held
      |-> $stable(step_number_o))
      else $error("step moved while held");
   AST_CLR_LEN: assert property ($fell(clearing_o)
      |-> clr_cnt == CLEAR_CYC)
      else $error("clear length wrong");
   AST_ONEHOT: assert property ($onehot({idle_o, run_o, hold_o,
      clearing_o}))
      else $error("mode flags not one-hot");
endmodule // ssc_top_monitor

bind ssc_top ssc_top_monitor #(.CLEAR_CYC(CLEAR_CYC)) i_ssc_top_monitor (
   .clock_i, .nrst_i, .output_on_i, .start_i, .stop_i, .hold_i,
   .branch_command_a_i, .branch_command_b_i, .ac_dc_internal_mode_i,
   .dc_level_o, .step_marker_code_o, .step_number_o, .idle_o, .run_o,
   .hold_o, .clearing_o
);

// ==== bench/ssc_cmd_src.sv ====
// Operator command source: turns an op code into one-cycle pulses.
// Assumes the bench changes go_i and op_i on the falling edge.
module ssc_cmd_src (
   // Request
   input wire logic go_i,
   input wire logic [2:0] op_i,
   input wire logic raw_i,
   input wire logic output_on_i,
   // Commands
   output logic start_o,
   output logic stop_o,
   output logic hold_o,
   output logic bra_o,
   output logic brb_o,
   output logic clear_o
);
   // ==========================================================
   // Only commands with output on, unless raw is asked for
   logic fire;
   assign fire = go_i && (output_on_i || raw_i);
   assign start_o = fire && op_i == 3'h1;
   assign stop_o = fire && op_i == 3'h2;
   assign hold_o = fire && op_i == 3'h3;
   assign bra_o = fire && op_i == 3'h4;
   assign brb_o = fire && op_i == 3'h5;
   assign clear_o = fire && op_i == 3'h6;
endmodule // ssc_cmd_src

// ==== bench/ssc_top_bench.sv ====
// Self-checking bench for ssc_top with a command source partner.
// Assumes shortened tick and clear counts.
module ssc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic output_on_i = 1'b0;
   logic go = 1'b0;
   logic raw = 1'b0;
   logic [2:0] op = 3'h0;
   logic range_200v_i = 1'b0;
   logic ac_dc_internal_mode_i = 1'b0;
   logic edit_we_i = 1'b0;
   logic [1:0] edit_bank_i = 2'h0;
   logic [7:0] edit_step_i = 8'h00;
   logic [ssc_pkg::REC_W-1:0] edit_data_i = '0;
   logic start_i, stop_i, hold_i, bra, brb, clear_i;
   logic [15:0] dc_level_o, ac_level_o;
   logic [1:0] step_marker_code_o;
   logic [7:0] step_number_o;
   logic idle_o, run_o, hold_o, clearing_o;
   logic [2:0] st;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   int seed = 53980;
   logic watch = 1'b0;
   logic [7:0] step_q[$];
   logic [15:0] v[4];
   logic [7:0] s;
   assign st = {run_o, hold_o, idle_o};
   always #12.5 clock_i = ~clock_i;
   ssc_cmd_src i_ssc_cmd_src (.go_i(go), .op_i(op), .raw_i(raw),
      .output_on_i, .start_o(start_i), .stop_o(stop_i), .hold_o(hold_i),
      .bra_o(bra), .brb_o(brb), .clear_o(clear_i));
   ssc_top #(.TICK_CYC(4), .CLEAR_CYC(2048)) i_ssc_top (.clock_i, .nrst_i,
      .output_on_i, .start_i, .stop_i, .hold_i, .branch_command_a_i(bra),
      .branch_command_b_i(brb), .clear_i, .range_200v_i,
      .ac_dc_internal_mode_i, .edit_we_i, .edit_bank_i, .edit_step_i,
      .edit_data_i, .dc_level_o, .ac_level_o, .step_marker_code_o,
      .step_number_o, .idle_o, .run_o, .hold_o, .clearing_o);
   // ==========================================================
   // Tasks
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input string w, input logic [15:0] seen,
      input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task automatic cmd(input logic [2:0] c);
      @(negedge clock_i);
      op = c;
      go = 1'b1;
      @(negedge clock_i);
      go = 1'b0;
   endtask
   task automatic edit(input logic [1:0] b, input logic [7:0] n,
      input logic [15:0] t, input logic [1:0] e, input logic [7:0] jt,
      input logic [9:0] jr, input logic [7:0] ba, input logic [15:0] a,
      input logic [15:0] d, input logic [1:0] mk);
      @(negedge clock_i);
      edit_bank_i = b;
      edit_step_i = n;
      edit_data_i = {2'h0, a, 2'h0, d, 1'b0, mk, 8'h00, ba, jr, jt, e, t};
      edit_we_i = 1'b1;
      @(negedge clock_i);
      edit_we_i = 1'b0;
   endtask
   task automatic wait_st(input int k);
      int n;
      for (n = 0; n < 4000; n++) begin
         if (st[k] === 1'b1) break;
         @(negedge clock_i);
      end
      check("wait", 16'(n < 4000), 16'h0001);
   endtask
   // ==========================================================
   // Step watcher and timeout
   always @(step_number_o) begin
      if (watch) begin
         check("step", 16'(step_number_o), 16'(step_q.pop_front()));
      end
   end
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         wrap_up();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      for (int i = 0; i < 4; i++) v[i] = 16'($random(seed));
      repeat (2) @(negedge clock_i);
      nrst_i = 1'b1;
      check("idle", 16'(idle_o), 16'h0001);
      output_on_i = 1'b1;
      cmd(3'h6);
      check("clearing", 16'(clearing_o), 16'h0001);
      cmd(3'h1);
      check("run", 16'(run_o), 16'h0000);
      wait_st(2);
      cmd(3'h2);
      check("idle", 16'(idle_o), 16'h0001);
      edit(2'h0, 8'h01, 16'h0006, 2'h0, 8'h00, 10'h000, 8'h00, v[0], v[3],
         2'h1);
      edit(2'h0, 8'h02, 16'h0001, 2'h0, 8'h01, 10'h002, 8'h00, v[1], v[3],
         2'h2);
      edit(2'h0, 8'h03, 16'h0001, 2'h2, 8'h00, 10'h000, 8'h00, v[2], v[3],
         2'h3);
      edit(2'h0, 8'h04, 16'h0001, 2'h1, 8'h00, 10'h000, 8'h06, v[2], v[3],
         2'h2);
      edit(2'h0, 8'h06, 16'h0001, 2'h1, 8'h00, 10'h000, 8'h00, v[1], v[3],
         2'h1);
      edit(2'h3, 8'h01, 16'h0001, 2'h1, 8'h00, 10'h000, 8'h00, v[1], v[2],
         2'h3);
      step_q = '{8'h02, 8'h01, 8'h02, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06,
         8'h07};
      watch = 1'b1;
      cmd(3'h1);
      check("run", 16'(run_o), 16'h0001);
      repeat (3) @(negedge clock_i);
      check("ac", ac_level_o, v[0]);
      check("dc", dc_level_o, 16'h0000);
      check("mark", 16'(step_marker_code_o), 16'h0001);
      edit(2'h0, 8'h01, 16'h0006, 2'h0, 8'h00, 10'h000, 8'h00, v[3], v[3],
         2'h1);
      repeat (2) @(negedge clock_i);
      check("ac", ac_level_o, v[3]);
      check("step", 16'(step_number_o), 16'h0001);
      wait_st(1);
      check("hold", 16'(hold_o), 16'h0001);
      check("queue", 16'(step_q.size()), 16'h0002);
      cmd(3'h5);
      check("hold", 16'(hold_o), 16'h0001);
      cmd(3'h4);
      check("run", 16'(run_o), 16'h0001);
      wait_st(0);
      watch = 1'b0;
      check("queue", 16'(step_q.size()), 16'h0000);
      output_on_i = 1'b0;
      raw = 1'b1;
      cmd(3'h1);
      check("idle", 16'(idle_o), 16'h0001);
      raw = 1'b0;
      output_on_i = 1'b1;
      cmd(3'h1);
      repeat (4) @(negedge clock_i);
      cmd(3'h3);
      check("hold", 16'(hold_o), 16'h0001);
      s = step_number_o;
      repeat (8) @(negedge clock_i);
      check("step", 16'(step_number_o), 16'(s));
      cmd(3'h1);
      check("run", 16'(run_o), 16'h0001);
      cmd(3'h2);
      check("idle", 16'(idle_o), 16'h0001);
      range_200v_i = 1'b1;
      ac_dc_internal_mode_i = 1'b1;
      cmd(3'h1);
      repeat (3) @(negedge clock_i);
      check("ac", ac_level_o, v[1]);
      check("dc", dc_level_o, v[2]);
      check("mark", 16'(step_marker_code_o), 16'h0003);
      wait_st(0);
      wrap_up();
   end
endmodule // ssc_top_bench
